// *** hdl/sdac_cfg.svh ***
// constants for the sigma-delta converter control block
`ifndef SDAC_CFG_SVH
`define SDAC_CFG_SVH
`define SDAC_MCLK_DIV      20
`define SDAC_MOD_CYC       512
`define SDAC_SMP_BASE      256
`define SDAC_MAX_MULT_LOG  3
`define SDAC_NOTCH_DEF     12'h146
`define SDAC_CAL_SETTLE    3
`define SDAC_ACC_W         34
`define SDAC_RES_LSB       10
`define SDAC_GAIN_UNITY    24'h400000
`define SDAC_FIFO_DEPTH    16
`define SDAC_ADDR_CTRL     5'h00
`define SDAC_ADDR_STAT     5'h04
`define SDAC_ADDR_DATA     5'h08
`define SDAC_ADDR_OFFS     5'h0c
`define SDAC_ADDR_GAIN     5'h10
`define SDAC_CTRL_GAIN     2:0
`define SDAC_CTRL_CHAN     3
`define SDAC_CTRL_WL       4
`define SDAC_CTRL_UNI      5
`define SDAC_CTRL_BO       6
`define SDAC_CTRL_CAL      9:7
`define SDAC_CTRL_NOTCH    27:16
`define SDAC_RESP_OKAY     2'h0
`define SDAC_RESP_SLVERR   2'h2
`define SDAC_INSEL_EXT     2'h0
`define SDAC_INSEL_ZERO    2'h1
`define SDAC_INSEL_FULL    2'h2
`endif

// *** hdl/sdac_pkg.sv ***
// types shared by the converter control block
package sdac_pkg;
    typedef enum logic [2:0] {
        SDAC_CAL_NONE, SDAC_CAL_SELF, SDAC_CAL_SYS_OFFS, SDAC_CAL_SYS_GAIN, SDAC_CAL_BACKGROUND
    } sdac_cal_mode_t;
    typedef enum logic [1:0] {SDAC_PH_IDLE, SDAC_PH_ZERO, SDAC_PH_FULL} sdac_phase_t;
    typedef struct packed {
        logic [4:0]     mdiv;
        logic [8:0]     mcnt;
        logic           sample;
        logic [33:0]    i1;
        logic [33:0]    i2;
        logic [33:0]    i3;
        logic [33:0]    d1;
        logic [33:0]    d2;
        logic [33:0]    d3;
        logic [11:0]    dec;
        logic [2:0]     gain;
        logic           chan;
        logic           wl;
        logic           uni;
        logic           bo;
        logic [11:0]    notch;
        logic [23:0]    offs;
        logic [23:0]    gcoef;
        sdac_phase_t    phase;
        sdac_cal_mode_t mode;
        logic           bg;
        logic [1:0]     settle;
        logic           pend;
        logic [23:0]    word;
        logic           rdy;
        logic           standby;
        logic           aw_got;
        logic           w_got;
        logic [4:0]     awaddr;
        logic [31:0]    wdata;
        logic [3:0]     wstrb;
        logic           bvalid;
        logic [1:0]     bresp;
        logic           rvalid;
        logic [31:0]    rdata;
        logic [1:0]     rresp;
    } sdac_state_t;
endpackage

// *** hdl/sdac_fifo.sv ***
// result fifo with valid/ready on both sides
`timescale 1ns/1ps
module sdac_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    input  wire logic             I_CLK,
    input  wire logic             I_RST,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    // honest flags straight from the fill count
    assign o_in_ready  = (count != (AW+1)'(DEPTH));
    assign o_out_valid = (count != '0);
    assign o_out_data  = mem[rd_ptr];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    // storage has no reset, only pointers and count do
    always_ff @(posedge I_CLK) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    // pointers wrap by the depth, which need not be a power of two
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// *** hdl/sdac_top.sv ***
// converter control: sampling pace, sinc3 filter, calibration, standby, axi4-lite registers
// Function
// - after reset the notch code gives a first notch near 60 Hz.
// - gain codes select 1 to 128 on both inputs.
// - input sample strobe rate follows master clock and gain up to x8; higher gains keep the x8 rate.
// - sinc3 filter refreshes the output register once per notch period.
// - host reads results at any rate up to refresh rate; each read served.
// - a calibration request write starts calibration at any moment.
// - self-calibration computes coefficients and keeps them on chip.
// - system calibration measures offset and gain with external parts in loop; only offset is taken off results.
// - background mode repeats self-calibration without further commands.
// - host may read and overwrite stored calibration coefficients.
// - while standby pin is asserted, activity is suspended.
// - output word is 16 bits when word-length bit is 0, else 24.
`timescale 1ns/1ps
`include "sdac_cfg.svh"
module sdac_top #(
    parameter int MCLK_DIV   = `SDAC_MCLK_DIV,
    parameter int FIFO_DEPTH = `SDAC_FIFO_DEPTH
) (
    input  wire logic        I_CLK,
    input  wire logic        I_RST,
    input  wire logic        I_MOD_BIT,
    input  wire logic        I_STANDBY_N,
    output logic             O_SAMPLE,
    output logic [2:0]       O_GAIN,
    output logic             O_CHANNEL,
    output logic             O_UNIPOLAR,
    output logic             O_BURNOUT,
    output logic [1:0]       O_IN_SEL,
    output logic             O_STANDBY,
    input  wire logic [4:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [4:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY
);
    sdac_pkg::sdac_state_t st;
    sdac_pkg::sdac_state_t next_st;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic [23:0] fifo_out_data;
    logic        fifo_pop;
    logic        pend_push;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // strobe spacing in master clocks: 256 at x1, halving up to 8 samples per base
    function automatic logic [8:0] smp_mask(input logic [2:0] g);
        logic [1:0] m;
        m = (g > 3'(`SDAC_MAX_MULT_LOG)) ? 2'(`SDAC_MAX_MULT_LOG) : g[1:0];
        smp_mask = 9'((`SDAC_SMP_BASE >> m) - 1);
    endfunction

    // byte-lane merge for a 32-bit register image
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        merge = r;
    endfunction

    function automatic logic [31:0] ctrl_image(input sdac_pkg::sdac_state_t s);
        logic [31:0] r;
        r = '0;
        r[`SDAC_CTRL_GAIN]  = s.gain;
        r[`SDAC_CTRL_CHAN]  = s.chan;
        r[`SDAC_CTRL_WL]    = s.wl;
        r[`SDAC_CTRL_UNI]   = s.uni;
        r[`SDAC_CTRL_BO]    = s.bo;
        r[`SDAC_CTRL_CAL]   = s.bg ? 3'(sdac_pkg::SDAC_CAL_BACKGROUND) : 3'(s.mode);
        r[`SDAC_CTRL_NOTCH] = s.notch;
        ctrl_image = r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // result fifo between output register and data register

    // a pending word waits here while the fifo is full, stalling refresh
    assign pend_push = st.pend;
    assign fifo_pop  = S_AXI_ARVALID && S_AXI_ARREADY && (S_AXI_ARADDR == `SDAC_ADDR_DATA) && fifo_out_valid;

    sdac_fifo #(
        .WIDTH (24),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .I_CLK       (I_CLK),
        .I_RST       (I_RST),
        .i_in_valid  (pend_push),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (st.word),
        .o_out_valid (fifo_out_valid),
        .i_out_ready (fifo_pop),
        .o_out_data  (fifo_out_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        logic        mtick;
        logic        mod_tick;
        logic        conv_done;
        logic        frst;
        logic        start_cal;
        logic        wr_fire;
        logic [33:0] c1;
        logic [33:0] c2;
        logic [33:0] c3;
        logic [23:0] res;
        logic [31:0] cimg;
        mtick     = 1'b0;
        mod_tick  = 1'b0;
        conv_done = 1'b0;
        frst      = 1'b0;
        start_cal = 1'b0;
        wr_fire   = 1'b0;
        c1        = '0;
        c2        = '0;
        c3        = '0;
        res       = '0;
        cimg      = '0;
        next_st   = st;
        next_st.sample  = 1'b0;
        next_st.standby = !I_STANDBY_N;

        // master clock pacing; standby freezes it and clears the filter
        if (!I_STANDBY_N) begin
            frst = 1'b1;
        end else if (st.mdiv == 5'(MCLK_DIV - 1)) begin
            next_st.mdiv = '0;
            mtick        = 1'b1;
        end else begin
            next_st.mdiv = st.mdiv + 1'b1;
        end

        // modulator cycle is 512 master clocks; samples more often at high gain
        if (mtick) begin
            next_st.mcnt   = st.mcnt + 1'b1;
            mod_tick       = (st.mcnt == 9'(`SDAC_MOD_CYC - 1));
            next_st.sample = ((st.mcnt & smp_mask(st.gain)) == '0);
        end

        // sinc3: three integrators at modulator rate, combs at notch rate
        if (mod_tick) begin
            next_st.i1 = st.i1 + 34'(I_MOD_BIT);
            next_st.i2 = st.i2 + st.i1;
            next_st.i3 = st.i3 + st.i2;
            if (st.dec >= st.notch - 1'b1) begin // first notch = mclk/512/code
                next_st.dec = '0;
                c1          = st.i3 - st.d1;
                c2          = c1 - st.d2;
                c3          = c2 - st.d3;
                next_st.d1  = st.i3;
                next_st.d2  = c1;
                next_st.d3  = c2;
                conv_done   = 1'b1;
            end else begin
                next_st.dec = st.dec + 1'b1;
            end
        end
        res = c3[`SDAC_RES_LSB +: 24];

        // calibration sequencing: results feed coefficients, not the output
        if (conv_done) begin
            if (st.phase == sdac_pkg::SDAC_PH_IDLE) begin
                if (!st.pend) begin
                    next_st.pend = 1'b1;
                    next_st.word = res - st.offs;
                    next_st.rdy  = 1'b1;
                end
                if (st.bg) begin // recalibrate after every result
                    next_st.mode  = sdac_pkg::SDAC_CAL_SELF;
                    next_st.phase = sdac_pkg::SDAC_PH_ZERO;
                    next_st.settle = '0;
                    frst          = 1'b1;
                end
            end else if (st.settle != 2'(`SDAC_CAL_SETTLE - 1)) begin
                next_st.settle = st.settle + 1'b1;
            end else begin
                next_st.settle = '0;
                frst           = 1'b1;
                if (st.phase == sdac_pkg::SDAC_PH_ZERO) begin
                    next_st.offs = res; // zero reading kept on chip
                    if (st.mode == sdac_pkg::SDAC_CAL_SYS_OFFS) begin
                        next_st.phase = sdac_pkg::SDAC_PH_IDLE;
                    end else begin
                        next_st.phase = sdac_pkg::SDAC_PH_FULL;
                    end
                end else begin
                    next_st.gcoef = res - st.offs; // full-scale span
                    next_st.phase = sdac_pkg::SDAC_PH_IDLE;
                end
            end
        end

        // push pending word as soon as fifo has room
        if (st.pend && fifo_in_ready) begin
            next_st.pend = 1'b0;
        end

        // write channel: address and data taken in either order
        if (S_AXI_AWVALID && !st.aw_got) begin
            next_st.aw_got = 1'b1;
            next_st.awaddr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && !st.w_got) begin
            next_st.w_got = 1'b1;
            next_st.wdata = S_AXI_WDATA;
            next_st.wstrb = S_AXI_WSTRB;
        end
        wr_fire = st.aw_got && st.w_got && !st.bvalid;
        if (wr_fire) begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = `SDAC_RESP_OKAY;
            unique case (st.awaddr)
                `SDAC_ADDR_CTRL: begin
                    cimg          = merge(ctrl_image(st), st.wdata, st.wstrb);
                    next_st.gain  = cimg[`SDAC_CTRL_GAIN];
                    next_st.chan  = cimg[`SDAC_CTRL_CHAN];
                    next_st.wl    = cimg[`SDAC_CTRL_WL];
                    next_st.uni   = cimg[`SDAC_CTRL_UNI];
                    next_st.bo    = cimg[`SDAC_CTRL_BO];
                    next_st.notch = cimg[`SDAC_CTRL_NOTCH];
                    if (st.wstrb[1] || st.wstrb[0]) begin
                        start_cal = 1'b1;
                    end
                end
                `SDAC_ADDR_OFFS: begin // host-supplied coefficients
                    if (!(conv_done && next_st.offs != st.offs)) begin
                        next_st.offs = 24'(merge({8'h00, st.offs}, st.wdata, st.wstrb));
                    end
                end
                `SDAC_ADDR_GAIN: begin // hardware update wins a same-cycle write
                    if (!(conv_done && next_st.gcoef != st.gcoef)) begin
                        next_st.gcoef = 24'(merge({8'h00, st.gcoef}, st.wdata, st.wstrb));
                    end
                end
                `SDAC_ADDR_STAT, `SDAC_ADDR_DATA: begin
                    next_st.bresp = `SDAC_RESP_OKAY;
                end
                default: begin
                    next_st.bresp = `SDAC_RESP_SLVERR;
                end
            endcase
        end

        // a calibration request restarts the sequence at any moment
        if (start_cal) begin
            next_st.bg     = 1'b0;
            next_st.settle = '0;
            next_st.phase  = sdac_pkg::SDAC_PH_IDLE;
            next_st.mode   = sdac_pkg::SDAC_CAL_NONE;
            frst           = 1'b1;
            unique case (cimg[`SDAC_CTRL_CAL])
                3'(sdac_pkg::SDAC_CAL_SELF), 3'(sdac_pkg::SDAC_CAL_SYS_OFFS): begin
                    next_st.mode  = sdac_pkg::sdac_cal_mode_t'(cimg[`SDAC_CTRL_CAL]);
                    next_st.phase = sdac_pkg::SDAC_PH_ZERO;
                end
                3'(sdac_pkg::SDAC_CAL_SYS_GAIN): begin
                    next_st.mode  = sdac_pkg::SDAC_CAL_SYS_GAIN;
                    next_st.phase = sdac_pkg::SDAC_PH_FULL;
                end
                3'(sdac_pkg::SDAC_CAL_BACKGROUND): begin
                    next_st.bg    = 1'b1;
                    next_st.mode  = sdac_pkg::SDAC_CAL_SELF;
                    next_st.phase = sdac_pkg::SDAC_PH_ZERO;
                end
                default: begin
                    next_st.mode = sdac_pkg::SDAC_CAL_NONE;
                end
            endcase
        end

        // filter restart discards partial sums so each phase settles cleanly
        if (frst) begin
            next_st.i1  = '0;
            next_st.i2  = '0;
            next_st.i3  = '0;
            next_st.d1  = '0;
            next_st.d2  = '0;
            next_st.d3  = '0;
            next_st.dec = '0;
            if (!I_STANDBY_N) begin
                next_st.mcnt = '0;
            end
        end

        if (st.bvalid && S_AXI_BREADY) begin
            next_st.bvalid = 1'b0;
        end

        // read channel; a data read pops one result
        if (S_AXI_ARVALID && !st.rvalid) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = `SDAC_RESP_OKAY;
            next_st.rdata  = '0;
            unique case (S_AXI_ARADDR)
                `SDAC_ADDR_CTRL: next_st.rdata = ctrl_image(st);
                `SDAC_ADDR_STAT: next_st.rdata = {28'h0000000, fifo_out_valid, st.standby,
                                                  st.phase != sdac_pkg::SDAC_PH_IDLE, st.rdy};
                `SDAC_ADDR_DATA: begin
                    if (fifo_out_valid) begin // 16-bit word is the top of the result
                        next_st.rdata = st.wl ? {8'h00, fifo_out_data} : {16'h0000, fifo_out_data[23:8]};
                    end
                    if (!(st.pend || next_st.pend)) begin
                        next_st.rdy = 1'b0;
                    end
                end
                `SDAC_ADDR_OFFS: next_st.rdata = {8'h00, st.offs};
                `SDAC_ADDR_GAIN: next_st.rdata = {8'h00, st.gcoef};
                default:         next_st.rresp = `SDAC_RESP_SLVERR;
            endcase
        end
        if (st.rvalid && S_AXI_RREADY) begin
            next_st.rvalid = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    // synchronous reset to power-on defaults
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            st       <= '0;
            st.notch <= `SDAC_NOTCH_DEF; // ~60 Hz first notch
            st.gcoef <= `SDAC_GAIN_UNITY;
            st.phase <= sdac_pkg::SDAC_PH_IDLE;
            st.mode  <= sdac_pkg::SDAC_CAL_NONE;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // analog-side controls; input mux follows the self-calibration phase
    assign O_SAMPLE      = st.sample;
    assign O_GAIN        = st.gain;
    assign O_CHANNEL     = st.chan;
    assign O_UNIPOLAR    = st.uni;
    assign O_BURNOUT     = st.bo;
    assign O_STANDBY     = st.standby;
    assign O_IN_SEL      = (st.phase == sdac_pkg::SDAC_PH_IDLE || st.mode != sdac_pkg::SDAC_CAL_SELF)
                           ? `SDAC_INSEL_EXT
                           : (st.phase == sdac_pkg::SDAC_PH_ZERO ? `SDAC_INSEL_ZERO : `SDAC_INSEL_FULL);
    assign S_AXI_AWREADY = !st.aw_got;
    assign S_AXI_WREADY  = !st.w_got;
    assign S_AXI_BVALID  = st.bvalid;
    assign S_AXI_BRESP   = st.bresp;
    assign S_AXI_ARREADY = !st.rvalid;
    assign S_AXI_RVALID  = st.rvalid;
    assign S_AXI_RDATA   = st.rdata;
    assign S_AXI_RRESP   = st.rresp;
endmodule

// *** tb/sdac_mod_src.sv ***
// modulator bit source standing in for the analog loop
`timescale 1ns/1ps
module sdac_mod_src #(
    parameter logic [23:0] LEVEL = 24'h9a0000
) (
    input  wire logic I_CLK,
    input  wire logic i_sample,
    output logic      o_bit
);
    logic [23:0] acc = 24'h0;
    initial o_bit = 1'h0;
    // first-order loop: the carry is the comparator decision, so density tracks level
    always @(posedge I_CLK) begin
        if (i_sample) begin
            {o_bit, acc} <= 25'(acc) + 25'(LEVEL);
        end
    end
endmodule

// *** tb/sdac_top_properties.sv ***
// concurrent checks on the converter control ports
`timescale 1ns/1ps
module sdac_top_properties #(
    parameter int MCLK_DIV = 20
) (
    input wire logic        I_CLK,
    input wire logic        I_RST,
    input wire logic        I_STANDBY_N,
    input wire logic        O_SAMPLE,
    input wire logic [2:0]  O_GAIN,
    input wire logic        O_STANDBY,
    input wire logic [4:0]  S_AXI_AWADDR,
    input wire logic        S_AXI_AWVALID,
    input wire logic        S_AXI_AWREADY,
    input wire logic        S_AXI_WVALID,
    input wire logic        S_AXI_WREADY,
    input wire logic [1:0]  S_AXI_BRESP,
    input wire logic        S_AXI_BVALID,
    input wire logic [4:0]  S_AXI_ARADDR,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic [1:0]  S_AXI_RRESP,
    input wire logic        S_AXI_RVALID
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    int         gap;
    int         exp_gap;
    logic       ok;
    logic [2:0] g_q;
    // expected strobe spacing; gains above 8 stop raising the rate
    assign exp_gap = ((256 * MCLK_DIV) >> ((O_GAIN > 3'h3) ? 3 : int'(O_GAIN))) - 1;
    // any bus write, gain change or standby spoils the next gap, so it is skipped
    always_ff @(posedge I_CLK) begin
        g_q <= O_GAIN;
        gap <= (I_RST || O_SAMPLE) ? 0 : gap + 1;
        ok  <= !I_RST && (ok || O_SAMPLE) && O_GAIN == g_q && I_STANDBY_N && !O_STANDBY
               && !S_AXI_AWVALID && !S_AXI_BVALID;
    end
    sequence wr_taken;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    sequence rd_taken;
        S_AXI_ARVALID && S_AXI_ARREADY;
    endsequence
    ////////////////////////////////
    a_sample_pulse: assert property (O_SAMPLE |=> !O_SAMPLE)
        else $error("sample strobe wider than one cycle");
    a_sample_gap: assert property (O_SAMPLE && ok |-> gap == exp_gap)
        else $error("sample spacing does not follow gain");
    a_standby_quiet: assert property (!I_STANDBY_N [*3] |-> O_STANDBY && !O_SAMPLE)
        else $error("activity while standby pin low");
    a_standby_exit: assert property (I_STANDBY_N [*2] |-> !O_STANDBY)
        else $error("standby flag stuck");
    a_reset_state: assert property (disable iff (1'b0) I_RST |=> !S_AXI_BVALID && !S_AXI_RVALID && O_GAIN == 3'h0)
        else $error("bad state after reset");
    a_wr_answer: assert property (wr_taken |-> ##2 S_AXI_BVALID)
        else $error("write response late");
    a_wr_unmapped: assert property (wr_taken ##0 S_AXI_AWADDR > 5'h10 |-> ##2 S_AXI_BRESP == 2'h2)
        else $error("unmapped write not refused");
    a_rd_answer: assert property (rd_taken |=> S_AXI_RVALID)
        else $error("read data late");
    a_rd_unmapped: assert property (rd_taken ##0 S_AXI_ARADDR > 5'h10 |=> S_AXI_RRESP == 2'h2)
        else $error("unmapped read not refused");
    a_ar_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read address taken while data pending");
endmodule
bind sdac_top sdac_top_properties #(.MCLK_DIV(MCLK_DIV)) u_props (.*);

// *** tb/sdac_top_tb.sv ***
// self-checking bench for the converter control block
`timescale 1ns/1ps
`include "sdac_cfg.svh"
module sdac_top_tb;
    localparam int DIV = 2; // short master clock divide keeps result periods brief
    logic        I_CLK = 1'h0, I_RST = 1'h1, I_STANDBY_N = 1'h1, mod_bit;
    logic        O_SAMPLE, O_CHANNEL, O_UNIPOLAR, O_BURNOUT, O_STANDBY;
    logic [2:0]  O_GAIN;
    logic [1:0]  O_IN_SEL, S_AXI_BRESP, S_AXI_RRESP;
    logic [4:0]  S_AXI_AWADDR = 5'h0, S_AXI_ARADDR = 5'h0;
    logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, rdv, c;
    logic [3:0]  S_AXI_WSTRB = 4'hf;
    logic        S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
    logic        S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
    logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic [65:0] rq[$], n;
    logic [1:0]  bq[$];
    int          fails = 0, total_checks = 0, cyc = 0, c1, c2;

    sdac_top #(.MCLK_DIV(DIV)) dut (.*, .I_MOD_BIT(mod_bit));
    sdac_mod_src u_mod (.I_CLK(I_CLK), .i_sample(O_SAMPLE), .o_bit(mod_bit));

    // clock and cycle count
    initial forever #2.5 I_CLK = ~I_CLK;
    always @(posedge I_CLK) cyc <= cyc + 1;
    ////////////////////////////////
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic rst;
        I_RST <= 1'h1;
        repeat (10) @(posedge I_CLK);
        I_RST <= 1'h0;
        @(posedge I_CLK);
    endtask
    // write: address and data offered together, each dropped once taken
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ad = 1'h0, wd = 1'h0;
        bq.push_back(r);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_AWVALID <= 1'h1;
        S_AXI_WVALID <= 1'h1;
        S_AXI_BREADY <= 1'h1;
        while (!(ad && wd)) begin
            @(posedge I_CLK);
            ad |= S_AXI_AWREADY;
            wd |= S_AXI_WREADY;
            S_AXI_AWVALID <= !ad;
            S_AXI_WVALID <= !wd;
        end
        do @(posedge I_CLK); while (!S_AXI_BVALID);
        S_AXI_BREADY <= 1'h0;
        @(posedge I_CLK);
    endtask
    // read: expectation noted first, a zero mask skips the data compare
    task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
        rq.push_back({((a > 5'h10) ? 2'h2 : 2'h0), m, e});
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'h1;
        S_AXI_RREADY <= 1'h1;
        do @(posedge I_CLK); while (!S_AXI_ARREADY);
        S_AXI_ARVALID <= 1'h0;
        do @(posedge I_CLK); while (!S_AXI_RVALID);
        rdv = S_AXI_RDATA;
        S_AXI_RREADY <= 1'h0;
        @(posedge I_CLK);
    endtask
    task automatic drain;
        repeat (16) rd(`SDAC_ADDR_DATA, 32'h0, 32'h0);
        rd(`SDAC_ADDR_DATA, 32'h0, 32'hffffffff);
    endtask
    task automatic poll(output int t);
        do rd(`SDAC_ADDR_STAT, 32'h0, 32'h0); while (!rdv[0]);
        t = cyc;
    endtask
    // response monitor: oldest note against each answer
    always @(posedge I_CLK) begin
        if (S_AXI_RVALID && S_AXI_RREADY) begin
            n = rq.pop_front();
            if (n[63:32] != 32'h0) cmp(S_AXI_RDATA & n[63:32], n[31:0] & n[63:32]);
            cmp(32'(S_AXI_RRESP), 32'(n[65:64]));
        end
        if (S_AXI_BVALID && S_AXI_BREADY) cmp(32'(S_AXI_BRESP), 32'(bq.pop_front()));
    end
    // hang guard past the result waits
    initial begin
        repeat (90000) @(posedge I_CLK);
        fails++;
        wrap_up;
    end
    ////////////////////////////////
    initial begin
        void'($urandom(32'h4a80fc1d));
        rst;
        rd(`SDAC_ADDR_CTRL, 32'h01460000, 32'hffffffff);
        rd(`SDAC_ADDR_OFFS, 32'h0, 32'hffffffff);
        rd(`SDAC_ADDR_GAIN, 32'h00400000, 32'hffffffff);
        for (int i = 0; i < 2; i++) begin
            c = $urandom & 32'h00ffffff;
            wr(i ? `SDAC_ADDR_GAIN : `SDAC_ADDR_OFFS, c, 2'h0);
            rd(i ? `SDAC_ADDR_GAIN : `SDAC_ADDR_OFFS, c, 32'hffffffff);
        end
        wr(5'h14, 32'hffffffff, 2'h2);
        rd(5'h1c, 32'h0, 32'h0);
        // every gain code with random options
        for (int g = 0; g < 8; g++) begin
            c = 32'h00130000 | 32'({4'($urandom), 3'(g)});
            wr(`SDAC_ADDR_CTRL, c, 2'h0);
            rd(`SDAC_ADDR_CTRL, c, 32'hffffffff);
            cmp(32'({O_BURNOUT, O_UNIPOLAR, O_CHANNEL, O_GAIN}), 32'({c[6], c[5], c[3], c[2:0]}));
            repeat (1100) @(posedge I_CLK);
        end
        I_STANDBY_N <= 1'h0;
        repeat (600) @(posedge I_CLK);
        rd(`SDAC_ADDR_STAT, 32'h4, 32'h4);
        I_STANDBY_N <= 1'h1;
        // result spacing is one notch period; 16-bit words leave the top half clear
        wr(`SDAC_ADDR_CTRL, 32'h00130000, 2'h0);
        drain;
        poll(c1);
        drain;
        poll(c2);
        cmp(32'(c2 - c1 > 19 * 512 * DIV - 16 && c2 - c1 < 19 * 512 * DIV + 16), 32'h1);
        rd(`SDAC_ADDR_DATA, 32'h0, 32'hffff0000);
        drain;
        // each calibration kind starts at once; a reset ends it
        for (int m = 1; m < 5; m++) begin
            wr(`SDAC_ADDR_CTRL, 32'h00130000 | 32'(m) << 7, 2'h0);
            rd(`SDAC_ADDR_CTRL, 32'(m) << 7, 32'h380);
            rd(`SDAC_ADDR_STAT, 32'h2, 32'h2);
            if (m == 1) begin
                repeat (20000) @(posedge I_CLK);
                cmp(32'(O_IN_SEL), 32'(`SDAC_INSEL_ZERO));
                rd(`SDAC_ADDR_STAT, 32'h0, 32'h1);
            end
            rst;
        end
        wrap_up;
    end
endmodule
